// >>> core/fsch_core.sv
// Status and configuration registers, write-enable latch, suspend state,
// security ID lock and hold pause of a serial flash device.
// Assumes command pulses on clock from the command decoder, one at a time;
// pins and the serial clock come from the host and are synchronised here.
`timescale 1ns/1ps

module fsch_core (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,

  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic si,

  // Mode, straps and stored bits
  input wire logic quad_mode,
  input wire logic pin_config_default,
  input wire logic nv_protect_pin_enable,
  input wire logic nv_secure_locked,
  input wire logic perm_lock_any,

  // Command pulses and their data
  input wire logic cmd_write_enable,
  input wire logic write_disable_cmd,
  input wire logic cmd_write_status,
  input wire logic [7:0] cfg_wr_data,
  input wire logic cmd_bp_write,
  input wire logic lock_protection_cmd,
  input wire logic cmd_program,
  input wire logic cmd_erase,
  input wire logic program_secure_id_cmd,
  input wire logic [fsch_pkg::SECID_ADDR_W-1:0] secid_addr,
  input wire logic lockout_secure_id_cmd,
  input wire logic cmd_write_suspend,
  input wire logic cmd_write_resume,
  input wire logic op_done,
  input wire logic cmd_soft_reset,

  // Register copies and pin state
  output logic [7:0] device_status,
  output logic [7:0] device_configuration,
  output logic hold_active,
  output logic so_oe_n,
  output logic quad_data_pins,

  // Command answers and link bytes
  output logic program_grant,
  output logic erase_grant,
  output logic secid_program_grant,
  output logic secid_refused,
  output logic bp_write_grant,
  output logic iface_reset,
  output logic nv_protect_pin_enable_store,
  output logic nv_protect_pin_enable_value,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid
);

  // ----------------------------------------------------------------------
  // Register packing
  // ----------------------------------------------------------------------

  // Status byte from internal state
  function automatic logic [7:0] fsch_pack_status(input fsch_pkg::fsch_core_t s);
    logic [7:0] v;
    v = 8'h00;
    v[fsch_pkg::ST_BUSY_LO] = s.busy;
    v[fsch_pkg::ST_BUSY_HI] = s.busy;
    v[fsch_pkg::ST_WEL] = s.write_enable_latch;
    v[fsch_pkg::ST_ERASE_SUSP] = s.erase_susp;
    v[fsch_pkg::ST_PROG_SUSP] = s.prog_susp;
    v[fsch_pkg::ST_LOCKDOWN] = s.lockdown;
    v[fsch_pkg::ST_SEC_LOCK] = s.sec_locked;
    return v;
  endfunction : fsch_pack_status

  // Configuration byte from internal state
  function automatic logic [7:0] fsch_pack_config(input fsch_pkg::fsch_core_t s);
    logic [7:0] v;
    v = 8'h00;
    v[fsch_pkg::CF_PIN_CONFIG] = s.pin_cfg;
    v[fsch_pkg::CF_NO_PERM_LOCK] = s.no_perm;
    v[fsch_pkg::CF_PROTECT_PIN_EN] = s.pin_en;
    return v;
  endfunction : fsch_pack_config

  // ----------------------------------------------------------------------
  // State and link side
  // ----------------------------------------------------------------------
  fsch_pkg::fsch_core_t r;
  fsch_pkg::fsch_core_t n;
  logic [3:0] pins_raw;
  logic link_toggle;
  logic [7:0] link_byte;

  // Raw pins in synchroniser order
  assign pins_raw[fsch_pkg::PIN_CS] = cs_n;
  assign pins_raw[fsch_pkg::PIN_SCK] = sck;
  assign pins_raw[fsch_pkg::PIN_HOLD] = hold_n;
  assign pins_raw[fsch_pkg::PIN_WP] = wp_n;

  // Byte capture on the serial clock
  fsch_link_rx u_link (
    .sck(sck),
    .rstn(rstn),
    .cs_n(cs_n),
    .hold_n(hold_n),
    .si(si),
    .hold_allowed(r.hold_en),
    .byte_toggle(link_toggle),
    .byte_value(link_byte)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Decoded pin levels and guards
  logic cs_act;
  logic sck_low;
  logic hold_low;
  logic may_write;
  logic cfg_protected;
  logic secid_ok;

  // Command handling, pins and hold pause
  always_comb begin
    n = r;
    // Answers last one cycle
    n.program_grant = 1'b0;
    n.erase_grant = 1'b0;
    n.secid_grant = 1'b0;
    n.secid_refused = 1'b0;
    n.bp_grant = 1'b0;
    n.iface_reset = 1'b0;
    n.nv_store = 1'b0;
    n.rx_valid = 1'b0;

    // Three-stage pin synchronisers, change when stages two and three agree
    n.sync1 = pins_raw;
    n.sync2 = r.sync1;
    n.sync3 = r.sync2;
    for (int i = 0; i < fsch_pkg::PIN_COUNT; i++) begin
      if (r.sync2[i] == r.sync3[i]) begin
        n.pins[i] = r.sync3[i];
      end
    end
    n.tog1 = link_toggle;
    n.tog2 = r.tog1;
    n.tog3 = r.tog2;

    // Pin levels and write guards
    cs_act = ~r.pins[fsch_pkg::PIN_CS];
    sck_low = ~r.pins[fsch_pkg::PIN_SCK];
    hold_low = ~r.pins[fsch_pkg::PIN_HOLD];
    may_write = r.write_enable_latch & ~r.busy;
    cfg_protected = ~r.pins[fsch_pkg::PIN_WP] & ~r.pin_cfg & r.pin_en;
    secid_ok = ~r.sec_locked & (secid_addr >= fsch_pkg::SECID_FACTORY_END);

    // Power-up load of stored and strapped values
    if (!r.loaded) begin
      n.loaded = 1'b1;
      n.pin_cfg = pin_config_default;
      n.pin_en = nv_protect_pin_enable;
      n.sec_locked = nv_secure_locked;
    end else begin
      // Write-enable latch set and clear
      if (cmd_write_enable && !r.busy) begin
        n.write_enable_latch = 1'b1;
      end
      if (write_disable_cmd || cmd_soft_reset) begin
        n.write_enable_latch = 1'b0;
      end

      // Array program and erase start
      if (cmd_program && may_write) begin
        n.busy = 1'b1;
        n.op = fsch_pkg::FSCH_OP_PROGRAM;
        n.program_grant = 1'b1;
      end
      if (cmd_erase && may_write) begin
        n.busy = 1'b1;
        n.op = fsch_pkg::FSCH_OP_ERASE;
        n.erase_grant = 1'b1;
      end

      // Security ID program, user area only, never after lockout
      if (program_secure_id_cmd) begin
        if (may_write && secid_ok) begin
          n.busy = 1'b1;
          n.op = fsch_pkg::FSCH_OP_SECID;
          n.secid_grant = 1'b1;
        end else begin
          n.secid_refused = 1'b1;
        end
      end
      if (lockout_secure_id_cmd && may_write) begin
        n.sec_locked = 1'b1;
        n.busy = 1'b1;
        n.op = fsch_pkg::FSCH_OP_SECID;
      end

      // Protection lock-down and block-protection write
      if (lock_protection_cmd) begin
        n.write_enable_latch = 1'b0;
        if (may_write) begin
          n.lockdown = 1'b1;
        end
      end
      if (cmd_bp_write) begin
        n.write_enable_latch = 1'b0;
        n.bp_grant = may_write & ~r.lockdown & ~cfg_protected;
      end

      // Configuration write through the status write command
      if (cmd_write_status) begin
        n.write_enable_latch = 1'b0;
        if (may_write && !cfg_protected) begin
          n.pin_cfg = cfg_wr_data[fsch_pkg::CF_PIN_CONFIG];
          n.pin_en = cfg_wr_data[fsch_pkg::CF_PROTECT_PIN_EN];
          n.nv_store = 1'b1;
          n.nv_value = cfg_wr_data[fsch_pkg::CF_PROTECT_PIN_EN];
        end
      end

      // Suspend parks a running erase or program
      if (cmd_write_suspend) begin
        n.write_enable_latch = 1'b0;
        if (r.busy && r.op == fsch_pkg::FSCH_OP_ERASE) begin
          n.erase_susp = 1'b1;
          n.busy = 1'b0;
          n.susp_op = r.op;
        end
        if (r.busy && r.op == fsch_pkg::FSCH_OP_PROGRAM) begin
          n.prog_susp = 1'b1;
          n.busy = 1'b0;
          n.susp_op = r.op;
        end
      end
      if (cmd_write_resume && !r.busy && (r.erase_susp || r.prog_susp)) begin
        n.erase_susp = 1'b0;
        n.prog_susp = 1'b0;
        n.busy = 1'b1;
        n.op = r.susp_op;
      end

      // Internal operation finished
      if (op_done && r.busy) begin
        n.busy = 1'b0;
        n.op = fsch_pkg::FSCH_OP_IDLE;
        n.write_enable_latch = 1'b0;
      end
    end
    // Permanent lock seen every cycle
    n.no_perm = ~perm_lock_any;

    // Hold pause, x1 and x2 modes with pins enabled only
    n.hold_en = ~r.pin_cfg & ~quad_mode;
    if (!r.hold) begin
      if (cs_act && hold_low && sck_low && r.hold_en) begin
        n.hold = 1'b1;
      end
    end else begin
      // Chip select rise resets the interface
      if (!cs_act && !r.cs_lost) begin
        n.cs_lost = 1'b1;
        n.iface_reset = 1'b1;
      end
      // Release once the hold pin is high with the clock low or chip select gone
      if (!hold_low && (sck_low || r.cs_lost || !cs_act)) begin
        n.hold = 1'b0;
        n.cs_lost = 1'b0;
      end
    end
    // Output path floats in hold or idle
    n.so_oe_n = ~cs_act | n.hold;
    n.quad_pins = r.pin_cfg | quad_mode;

    // Finished byte from the link side
    if (r.tog2 == r.tog3 && r.tog3 != r.tog_ref) begin
      n.tog_ref = r.tog3;
      if (cs_act) begin
        n.rx_valid = 1'b1;
        n.rx_byte = link_byte;
      end
    end

    // Readable copies, valid whatever is running
    n.status_q = fsch_pack_status(n);
    n.config_q = fsch_pack_config(n);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Whole state on the core clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.sync1 <= fsch_pkg::PIN_RESET;
      r.sync2 <= fsch_pkg::PIN_RESET;
      r.sync3 <= fsch_pkg::PIN_RESET;
      r.pins <= fsch_pkg::PIN_RESET;
      r.op <= fsch_pkg::FSCH_OP_IDLE;
      r.susp_op <= fsch_pkg::FSCH_OP_IDLE;
      r.no_perm <= 1'b1;
      r.so_oe_n <= 1'b1;
      r.status_q <= fsch_pkg::STATUS_RESET;
      r.config_q <= fsch_pkg::CONFIG_RESET;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from state flip-flops
  // ----------------------------------------------------------------------
  // Register copies
  assign device_status = r.status_q;
  assign device_configuration = r.config_q;

  // Hold and pin use
  assign hold_active = r.hold;
  assign so_oe_n = r.so_oe_n;
  assign quad_data_pins = r.quad_pins;

  // One-cycle command answers
  assign program_grant = r.program_grant;
  assign erase_grant = r.erase_grant;
  assign secid_program_grant = r.secid_grant;
  assign secid_refused = r.secid_refused;
  assign bp_write_grant = r.bp_grant;
  assign iface_reset = r.iface_reset;

  // Stored enable and link bytes
  assign nv_protect_pin_enable_store = r.nv_store;
  assign nv_protect_pin_enable_value = r.nv_value;
  assign rx_byte = r.rx_byte;
  assign rx_byte_valid = r.rx_valid;

endmodule : fsch_core

// >>> core/fsch_pkg.sv
// Constants, field positions and state types for the flash status,
// configuration and hold block.
// Assumes the command decoder outside hands over one-cycle command pulses.
//
// Notes on behaviour
// - 2 KByte security ID, 64-bit factory segment
// - After lockout, user security ID writes refused
// - Security ID never erased; factory part unwritable
// - Hold only in x1/x2 modes, pin-enabled
// - Hold starts at falling hold during clock low
// - Hold ends at rising hold, clock low
// - In hold: output floats, input and clock ignored
// - Chip select rise in hold resets interface
// - Status bit layout, busy twice, bit 6 zero
// - Status read-only, readable while busy
// - Write commands refused without write-enable latch
// - Listed events clear the write-enable latch
// - Erase suspend sets, resume clears its flag
// - Program suspend sets, resume clears its flag
// - Lock-down status set; cleared by power cycle
// - Security lock sticky, reloaded at power-up
// - Busy high throughout internal erase or program
// - Config bit 1 pin configuration, reserved zero
// - Config bit 3 shows no permanent lock
// - Config bit 7 is protect pin enable
// - Pin configuration one makes pins quad data
// - Protect pin enable kept across power-down
package fsch_pkg;

  // ----------------------------------------------------------------------
  // Register field positions
  // ----------------------------------------------------------------------
  localparam int ST_BUSY_LO = 0;
  localparam int ST_WEL = 1;
  localparam int ST_ERASE_SUSP = 2;
  localparam int ST_PROG_SUSP = 3;
  localparam int ST_LOCKDOWN = 4;
  localparam int ST_SEC_LOCK = 5;
  localparam int ST_BUSY_HI = 7;
  localparam int CF_PIN_CONFIG = 1;
  localparam int CF_NO_PERM_LOCK = 3;
  localparam int CF_PROTECT_PIN_EN = 7;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h08;

  // ----------------------------------------------------------------------
  // Security ID space
  // ----------------------------------------------------------------------
  localparam int SECID_BYTES = 2048;
  localparam int SECID_ADDR_W = 11;
  localparam int SECID_FACTORY_BITS = 64;
  localparam logic [SECID_ADDR_W-1:0] SECID_FACTORY_END = 11'(SECID_FACTORY_BITS / 8);

  // ----------------------------------------------------------------------
  // Pin synchroniser layout and link counts
  // ----------------------------------------------------------------------
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_HOLD = 2;
  localparam int PIN_WP = 3;
  localparam int PIN_COUNT = 4;
  localparam logic [3:0] PIN_RESET = 4'hD;
  localparam logic [2:0] LINK_BIT_LAST = 3'h7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FSCH_OP_IDLE,
    FSCH_OP_PROGRAM,
    FSCH_OP_ERASE,
    FSCH_OP_SECID
  } fsch_op_t;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] pins;
    logic tog1;
    logic tog2;
    logic tog3;
    logic tog_ref;
    logic loaded;
    logic busy;
    fsch_op_t op;
    fsch_op_t susp_op;
    logic write_enable_latch;
    logic erase_susp;
    logic prog_susp;
    logic lockdown;
    logic sec_locked;
    logic pin_cfg;
    logic pin_en;
    logic no_perm;
    logic hold;
    logic cs_lost;
    logic hold_en;
    logic [7:0] status_q;
    logic [7:0] config_q;
    logic so_oe_n;
    logic quad_pins;
    logic program_grant;
    logic erase_grant;
    logic secid_grant;
    logic secid_refused;
    logic bp_grant;
    logic iface_reset;
    logic nv_store;
    logic nv_value;
    logic [7:0] rx_byte;
    logic rx_valid;
  } fsch_core_t;

endpackage : fsch_pkg

// >>> core/fsch_link_rx.sv
// Serial-clock side of the block: shifts in single-bit data bytes.
// Assumes the host changes the hold pin only while the serial clock is low.
`timescale 1ns/1ps

module fsch_link_rx (
  input wire logic sck,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic si,
  input wire logic hold_allowed,
  output logic byte_toggle,
  output logic [7:0] byte_value
);

  logic allow1_reg;
  logic allow2_reg;
  logic allow3_reg;
  logic allow_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic frame_rst_n;
  logic frozen;

  // Frame ends asynchronously with chip select
  assign frame_rst_n = rstn & ~cs_n;
  // Clock edges ignored while held
  assign frozen = ~hold_n & allow_reg;

  // --------------------------------------------------------------------
  // Bit position, cleared by each chip select rise
  // --------------------------------------------------------------------
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
    end else if (!frozen) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= {shift_reg[5:0], si};
    end
  end

  // --------------------------------------------------------------------
  // Hold enable crossing and finished byte hand-off
  // --------------------------------------------------------------------
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      allow1_reg <= 1'b0;
      allow2_reg <= 1'b0;
      allow3_reg <= 1'b0;
      allow_reg <= 1'b0;
      byte_toggle <= 1'b0;
      byte_value <= 8'h00;
    end else begin
      allow1_reg <= hold_allowed;
      allow2_reg <= allow1_reg;
      allow3_reg <= allow2_reg;
      // Enable taken once stages two and three agree
      if (allow2_reg == allow3_reg) begin
        allow_reg <= allow3_reg;
      end
      if (!frozen && !cs_n && bit_cnt_reg == fsch_pkg::LINK_BIT_LAST) begin
        byte_value <= {shift_reg, si};
        byte_toggle <= ~byte_toggle;
      end
    end
  end

endmodule : fsch_link_rx

// >>> testbench/fsch_core_sva.sv
// Checker for the status, configuration and hold block.
// Assumes it is bound to fsch_core and sees only that module's ports.
`timescale 1ns/1ps

module fsch_core_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire logic quad_mode,
  input wire logic perm_lock_any,
  input wire logic write_disable_cmd,
  input wire logic cmd_write_status,
  input wire logic cmd_write_suspend,
  input wire logic cmd_write_resume,
  input wire logic cmd_soft_reset,
  input wire logic op_done,
  input wire logic [fsch_pkg::SECID_ADDR_W-1:0] secid_addr,
  input wire logic [7:0] device_status,
  input wire logic [7:0] device_configuration,
  input wire logic hold_active,
  input wire logic so_oe_n,
  input wire logic quad_data_pins,
  input wire logic program_grant,
  input wire logic secid_program_grant,
  input wire logic iface_reset
);
  // ------------------------------------------------------------
  // Clocking and multi-step sequences
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Program granted, then suspended on the next cycle
  sequence s_prog_suspend;
    program_grant ##1 (cmd_write_suspend && !op_done);
  endsequence
  // Permanent lock seen steady for four cycles
  sequence s_perm_steady;
    perm_lock_any [*4];
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_busy_copies_equal: assert property (device_status[0] == device_status[7])
    else $error("busy copies differ");
  a_reserved_bits_zero: assert property (!device_status[6] &&
    (device_configuration & 8'h75) == 8'h00) else $error("reserved bit set");
  a_no_perm_lock: assert property (s_perm_steady |-> !device_configuration[3])
    else $error("permanent lock not shown");
  a_grant_needs_wel: assert property (program_grant |-> $past(device_status[1]))
    else $error("program granted without write enable");
  a_wel_cleared: assert property ((write_disable_cmd || cmd_write_suspend ||
    cmd_soft_reset || cmd_write_status) |=> !device_status[1]) else $error("latch kept");
  a_busy_holds: assert property (device_status[0] && !op_done &&
    !cmd_write_suspend |=> device_status[0]) else $error("busy dropped early");
  a_suspend_flag: assert property (s_prog_suspend |=>
    device_status[3] && !device_status[0]) else $error("program suspend not shown");
  a_resume_clears: assert property (device_status[3] && cmd_write_resume |=>
    !device_status[3] && device_status[0]) else $error("resume not shown");
  a_lockdown_sticky: assert property (device_status[4] |=> device_status[4])
    else $error("lock-down status cleared");
  a_seclock_sticky: assert property (device_status[5] |=> device_status[5])
    else $error("security lock cleared");
  a_secid_guard: assert property (secid_program_grant |-> !$past(device_status[5])
    && $past(secid_addr) >= 11'h008) else $error("security id write granted");
  a_hold_floats: assert property (hold_active |-> so_oe_n)
    else $error("output driven in hold");
  a_reset_held: assert property (iface_reset |-> hold_active)
    else $error("hold lost at chip select rise");
  a_quad_pins: assert property (quad_mode |=> quad_data_pins)
    else $error("quad mode pins not data");
endmodule : fsch_core_sva

// >>> testbench/fsch_host.sv
// Host model of the serial link: chip select, clock, data in, hold.
// Assumes the caller orders frames; link clock period 160 ns.
`timescale 1ns/1ps

module fsch_host (
  output logic cs_n,
  output logic sck,
  output logic hold_n,
  output logic si
);
  // Idle levels, clock parked low outside frames
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    hold_n = 1'b1;
    si = 1'b0;
  end
  // Hold released before chip select falls
  task automatic frame_start();
    #37 hold_n = 1'b1;
    #43 cs_n = 1'b0;
    #80;
  endtask : frame_start
  // One byte, top bit first, sampled on the rising clock
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      si = b[i];
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    si = ~si; // Never parks on the last bit
  endtask : send_byte
  // Hold moves only while the clock is low
  task automatic set_hold(input logic v);
    #80 hold_n = v;
    #80;
  endtask : set_hold
  task automatic frame_end();
    #80 cs_n = 1'b1;
    si = ~si;
  endtask : frame_end
endmodule : fsch_host

// >>> testbench/tb.sv
// Testbench top: commands, straps and a host link around the block.
// Assumes a 40 MHz core clock; the host model makes the link clock.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

module tb;
  localparam int WE = 0, WD = 1, WS = 2, BP = 3, LP = 4, PG = 5, ER = 6;
  localparam int PS = 7, LS = 8, SU = 9, RS = 10, DN = 11, SR = 12;
  logic clock = 1'b0, rstn = 1'b1, quad_mode = 1'b0, pin_config_default = 1'b0;
  logic nv_protect_pin_enable = 1'b0, nv_secure_locked = 1'b0, perm_lock_any = 1'b0;
  logic wp_n = 1'b1;
  logic [12:0] cmd = 13'h0000;
  logic [7:0] cfg_wr_data = 8'h00, d;
  logic [10:0] secid_addr = 11'h000;
  wire cmd_write_enable, write_disable_cmd, cmd_write_status, cmd_bp_write;
  wire lock_protection_cmd, cmd_program, cmd_erase, program_secure_id_cmd;
  wire lockout_secure_id_cmd, cmd_write_suspend, cmd_write_resume, op_done, cmd_soft_reset;
  logic sck, cs_n, hold_n, si, hold_active, so_oe_n, quad_data_pins, program_grant;
  logic erase_grant, secid_program_grant, secid_refused, bp_write_grant, iface_reset;
  logic nv_protect_pin_enable_store, nv_protect_pin_enable_value, rx_byte_valid;
  logic [7:0] device_status, device_configuration, rx_byte, wd[3];
  int errors = 0, checked = 0, seed = 50, rx_seen = 0, rst_seen = 0, ev[4];

  // Command pulses fan out from one vector
  assign {cmd_soft_reset, op_done, cmd_write_resume, cmd_write_suspend, lockout_secure_id_cmd,
    program_secure_id_cmd, cmd_erase, cmd_program, lock_protection_cmd, cmd_bp_write,
    cmd_write_status, write_disable_cmd, cmd_write_enable} = cmd;

  fsch_host host (.cs_n, .sck, .hold_n, .si);
  fsch_core DUT (.clock, .rstn, .sck, .cs_n, .hold_n, .wp_n, .si, .quad_mode,
    .pin_config_default, .nv_protect_pin_enable, .nv_secure_locked, .perm_lock_any,
    .cmd_write_enable, .write_disable_cmd, .cmd_write_status, .cfg_wr_data, .cmd_bp_write,
    .lock_protection_cmd, .cmd_program, .cmd_erase, .program_secure_id_cmd, .secid_addr,
    .lockout_secure_id_cmd, .cmd_write_suspend, .cmd_write_resume, .op_done,
    .cmd_soft_reset, .device_status, .device_configuration, .hold_active, .so_oe_n,
    .quad_data_pins, .program_grant, .erase_grant, .secid_program_grant, .secid_refused,
    .bp_write_grant, .iface_reset, .nv_protect_pin_enable_store, .nv_protect_pin_enable_value, .rx_byte, .rx_byte_valid);

  // Core clock, 25 ns
  initial forever #12.5 clock = ~clock;

  // Counts link bytes and interface resets
  always @(posedge clock) begin
    if (rx_byte_valid === 1'b1) rx_seen <= rx_seen + 1;
    if (iface_reset === 1'b1) rst_seen <= rst_seen + 1;
  end

  function automatic logic [7:0] exp_st(input logic b, w, e, p, l, s);
    return {b, 1'h0, s, l, p, e, w, b};
  endfunction : exp_st
  function automatic logic [7:0] exp_cfg(input logic [7:0] v, input logic perm);
    return {v[7], 3'h0, ~perm, 1'h0, v[1], 1'h0};
  endfunction : exp_cfg
  // One command pulse; returns once the answer has landed
  task automatic pulse(input int b);
    @(posedge clock) cmd <= 13'h0001 << b;
    @(posedge clock) cmd <= 13'h0000;
    #1;
  endtask : pulse
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_clk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  // Watchdog
  initial begin
    #400000;
    errors++;
    final_report();
  end

  // Main sequence
  initial begin
    rstn <= 1'b0; // Falling edge reaches the link side too
    ev = '{WD, SU, SR, WS};
    wd = '{8'hFF, 8'h00, 8'h00};
    wd[1] = $random(seed);
    wait_clk(5);
    @(posedge clock) rstn <= 1'b1;
    wait_clk(6);
    `CHK("status", exp_st(0, 0, 0, 0, 0, 0), device_status);
    `CHK("config", exp_cfg(8'h00, 1'h0), device_configuration);
    pulse(PG);
    `CHK("grant", 1'h0, program_grant);
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      pulse(WE);
      pulse(k ? ER : PG);
      `CHK("grant", 1'h1, k ? erase_grant : program_grant);
      `CHK("status", exp_st(1, 1, 0, 0, 0, 0), device_status);
      pulse(SU);
      `CHK("status", exp_st(0, 0, k == 1, k == 0, 0, 0), device_status);
      pulse(RS);
      `CHK("status", exp_st(1, 0, 0, 0, 0, 0), device_status);
      pulse(DN);
      `CHK("status", exp_st(0, 0, 0, 0, 0, 0), device_status);
    end
    foreach (ev[i]) begin
      pulse(WE);
      pulse(ev[i]);
      `CHK("latch", 1'h0, device_status[1]);
    end
    foreach (wd[i]) begin
      @(posedge clock) cfg_wr_data <= wd[i];
      pulse(WE);
      pulse(WS);
      `CHK("config", exp_cfg(wd[i], 1'h0), device_configuration);
      `CHK("pin enable store", 1'h1, nv_protect_pin_enable_store);
      `CHK("pin enable store", wd[i][7], nv_protect_pin_enable_value);
    end
    $display("test status done");
    pulse(WE);
    pulse(BP);
    `CHK("bp grant", 1'h1, bp_write_grant);
    `CHK("latch", 1'h0, device_status[1]);
    pulse(WE);
    pulse(LP);
    `CHK("status", exp_st(0, 0, 0, 0, 1, 0), device_status);
    pulse(WE);
    pulse(BP);
    `CHK("bp grant", 1'h0, bp_write_grant);
    d = $random(seed);
    @(posedge clock) secid_addr <= {8'h00, d[2:0]};
    pulse(WE);
    pulse(PS);
    `CHK("secid refused", 1'h1, secid_refused);
    @(posedge clock) secid_addr <= 11'h008 | {d, 3'h0};
    pulse(WE);
    pulse(PS);
    `CHK("secid grant", 1'h1, secid_program_grant);
    `CHK("busy", 1'h1, device_status[0]);
    pulse(DN);
    pulse(WE);
    pulse(LS);
    `CHK("lock busy", 2'h3, {device_status[5], device_status[0]});
    pulse(DN);
    `CHK("status", exp_st(0, 0, 0, 0, 1, 1), device_status);
    @(posedge clock) secid_addr <= 11'h7FF;
    pulse(WE);
    pulse(PS);
    `CHK("secid refused", 1'h1, secid_refused);
    $display("test secid done");
    host.frame_start();
    host.send_byte(d);
    wait_clk(8);
    `CHK("rx byte", d, rx_byte);
    host.set_hold(1'b0);
    wait_clk(8);
    `CHK("hold", 2'h3, {hold_active, so_oe_n});
    host.send_byte(~d);
    wait_clk(8);
    `CHK("bytes", 1, rx_seen);
    host.frame_end();
    wait_clk(8);
    `CHK("iface resets", 1, rst_seen);
    `CHK("hold", 1'h1, hold_active);
    host.set_hold(1'b1);
    wait_clk(8);
    `CHK("hold", 1'h0, hold_active);
    @(posedge clock) quad_mode <= 1'b1;
    host.frame_start();
    host.set_hold(1'b0);
    wait_clk(8);
    `CHK("hold quad", 2'h1, {hold_active, quad_data_pins});
    host.frame_end();
    host.set_hold(1'b1);
    $display("test hold done");
    @(posedge clock) begin
      quad_mode <= 1'b0;
      rstn <= 1'b0;
      {nv_secure_locked, nv_protect_pin_enable, pin_config_default, perm_lock_any} <= 4'hF;
    end
    wait_clk(5);
    @(posedge clock) rstn <= 1'b1;
    wait_clk(6);
    `CHK("status", exp_st(0, 0, 0, 0, 0, 1), device_status);
    `CHK("config", exp_cfg(8'h82, 1'h1), device_configuration);
    `CHK("quad pins", 1'h1, quad_data_pins);
    $display("test power-up done");
    final_report();
  end
endmodule : tb

bind fsch_core fsch_core_sva u_sva (.clock, .rstn, .quad_mode, .perm_lock_any,
  .write_disable_cmd, .cmd_write_status, .cmd_write_suspend, .cmd_write_resume,
  .cmd_soft_reset, .op_done, .secid_addr, .device_status, .device_configuration,
  .hold_active, .so_oe_n, .quad_data_pins, .program_grant, .secid_program_grant,
  .iface_reset);
